/* File: shared/mfr_defs.svh */
// Constants of the multi-lane fast read engine: opcodes, phase lengths, dummy counts.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef MFR_DEFS_SVH
`define MFR_DEFS_SVH

`define MFR_OP_DUAL_OUT 8'h3B
`define MFR_OP_QUAD_OUT 8'h6B
`define MFR_OP_DUAL_IO 8'hBB
`define MFR_OP_QUAD_IO 8'hEB

`define MFR_CONT_KEY 4'hA
`define MFR_CMD_BITS 5'd8
`define MFR_ADDR_BITS 5'd24
`define MFR_MODE_BITS 5'd8
`define MFR_BYTE_BITS 4'd8
`define MFR_DUMMY_FIXED 5'd8
`define MFR_DUMMY_SPI_QIO 5'd4
`define MFR_DUMMY_DIO 5'd0
`define MFR_FOUR_DUMMY_P0 5'd4
`define MFR_FOUR_DUMMY_P1 5'd6
`define MFR_FOUR_DUMMY_P2 5'd8
`define MFR_FOUR_MODE_CLKS 5'd2
`define MFR_WRAP_BASE 8'h08

`endif

/* File: shared/mfr_pkg.sv */
// Types shared by the fast read engine.
// Assumes nothing beyond a SystemVerilog compiler.
package mfr_pkg;
    typedef enum logic [2:0] {
        MFR_IDLE = 3'b000,
        MFR_CMD = 3'b001,
        MFR_ADDR = 3'b010,
        MFR_MODE = 3'b011,
        MFR_DUMMY = 3'b100,
        MFR_DATA = 3'b101,
        MFR_IGN = 3'b110
    } mfr_state_t;
endpackage

/* File: hdl/mfr_sync.sv */
// Two-flop synchroniser for a group of independent levels.
// Assumes each bit is a slow level relative to the sampling clock.
`timescale 1ns/100ps
`default_nettype none
module mfr_sync #(
    parameter int W = 1
) (
    input wire logic sys_clk_i, // Sampling clock
    input wire logic resetn_i, // Async reset, active low
    input wire logic [W-1:0] rst_val_i, // Unused at reset; kept constant below
    input wire logic [W-1:0] d_i, // Asynchronous inputs
    output logic [W-1:0] q_o // Synchronised outputs
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta_q <= '1;
            sync_q <= '1;
        end else begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    // Only the second stage leaves the module
    assign q_o = sync_q & (rst_val_i | ~rst_val_i);
endmodule
`default_nettype wire

/* File: hdl/mfr_engine.sv */
// Read-command engine of a serial flash: dual/quad output and dual/quad I/O fast reads.
// Assumes pins sampled by sys_clk at far above the link rate, and a combinational
// array read port on mem_addr_o / mem_data_i in the sys_clk domain.
`timescale 1ns/100ps
`default_nettype none
`include "mfr_defs.svh"

// Operation
// - Dual-output read waits eight dummy clocks after the 24-bit address.
// - Dual-output data phase drives two bits per clock on lanes zero and one.
// - Quad-output read refused unless the quad lane enable bit is one.
// - Quad-output read: eight dummy clocks, then four bits per clock.
// - Dual I/O read moves address and data over two lanes.
// - I/O reads take a mode byte after address; only its upper nibble counts.
// - Upper nibble A lets the next same read skip the opcode.
// - Any other upper nibble means the next frame starts with an opcode.
// - Quad I/O read with opcode accepted only while quad lane enable bit is set.
// - Wrap setting steers wrap-around of single-lane-mode quad I/O reads.
// - Wrapped output restarts at the start of its aligned 8-64 byte section.
// - Four-lane mode quad I/O dummy count is 4, 6 or 8 by parameter bits.
// - Four-lane mode keeps continuation; mode clocks count as dummy clocks.
// - Four-lane mode quad I/O reads never wrap.
// - Byte address advances as each byte is fetched, on that byte's first falling edge during data.
// - Data launched on falling edges MSB first; inputs sampled on rising edges.
// - Read commands arriving while busy are ignored.
module mfr_engine
    import mfr_pkg::*;
(
    input wire logic sys_clk_i, // 250 MHz system clock
    input wire logic resetn_i, // Async reset, active low
    input wire logic cs_n_i, // Chip select pin, active low
    input wire logic sck_i, // Serial clock pin
    input wire logic [3:0] lane_i, // Lanes three..zero, pin level
    output logic [3:0] lane_o, // Lane drive values
    output logic [3:0] lane_oe_o, // Lane output enables, high drives
    input wire logic quad_lane_enable_bit_i, // Quad enable status bit
    input wire logic four_lane_command_mode_i, // Four-lane command mode active
    input wire logic busy_i, // Program/erase/status write in progress
    input wire logic wrap_en_i, // Burst wrap enabled by wrap setting
    input wire logic [1:0] wrap_len_i, // 0:8 1:16 2:32 3:64 bytes
    input wire logic [1:0] read_param_i, // Read parameter bits P5:P4
    input wire logic [7:0] mem_data_i, // Array byte at mem_addr_o
    output logic [23:0] mem_addr_o, // Array byte address
    output logic cont_mode_o // Continuation mode armed
);
    logic [5:0] pins_s;
    logic cs_s, sck_s, rise, fall;
    logic [3:0] lane_s;
    mfr_state_t st_q, st_d;
    logic sck_prev_q, sck_prev_d;
    logic [4:0] cnt_q, cnt_d;
    logic [23:0] sh_q, sh_d, sh_in;
    logic [7:0] op_q, op_d, cont_op_q, cont_op_d;
    logic cont_q, cont_d, wrap_q, wrap_d;
    logic [23:0] addr_q, addr_d;
    logic [7:0] dsh_q, dsh_d, byte_v;
    logic [3:0] rem_q, rem_d;
    logic [3:0] lane_q, lane_d, oe_q, oe_d;
    logic [2:0] iw;
    logic [4:0] dum;

    mfr_sync #(.W(6)) u_sync (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .rst_val_i(6'h3F),
        .d_i({cs_n_i, sck_i, lane_i}),
        .q_o(pins_s)
    );
    assign cs_s = pins_s[5];
    assign sck_s = pins_s[4];
    assign lane_s = pins_s[3:0];
    assign rise = sck_s & ~sck_prev_q;
    assign fall = ~sck_s & sck_prev_q;

    // Lanes used to receive address and mode bits
    function automatic logic [2:0] addr_w(input logic [7:0] op, input logic four);
        if (four || op == `MFR_OP_QUAD_IO) addr_w = 3'd4;
        else if (op == `MFR_OP_DUAL_IO) addr_w = 3'd2;
        else addr_w = 3'd1;
    endfunction

    // Lanes used to send data
    function automatic logic [2:0] data_w(input logic [7:0] op);
        if (op == `MFR_OP_QUAD_OUT || op == `MFR_OP_QUAD_IO) data_w = 3'd4;
        else data_w = 3'd2;
    endfunction

    function automatic logic [4:0] clocks(input logic [4:0] bits, input logic [2:0] w);
        clocks = bits / {2'b00, w};
    endfunction

    function automatic logic [23:0] next_addr(input logic [23:0] a, input logic wr,
                                             input logic [1:0] wl);
        logic [7:0] m;
        logic [23:0] inc;
        m = (`MFR_WRAP_BASE << wl) - 8'h01;
        inc = a + 24'h000001;
        if (wr) next_addr = {a[23:8], (a[7:0] & ~m) | (inc[7:0] & m)};
        else next_addr = inc;
    endfunction

    // Incoming bits, highest lane carries the highest bit of the group
    always_comb begin
        iw = (st_q == MFR_CMD) ? (four_lane_command_mode_i ? 3'd4 : 3'd1)
                               : addr_w(op_q, four_lane_command_mode_i);
        case (iw)
            3'd4: sh_in = {sh_q[19:0], lane_s};
            3'd2: sh_in = {sh_q[21:0], lane_s[1:0]};
            default: sh_in = {sh_q[22:0], lane_s[0]};
        endcase
        case (read_param_i)
            2'b00: dum = `MFR_FOUR_DUMMY_P0;
            2'b01: dum = `MFR_FOUR_DUMMY_P1;
            default: dum = `MFR_FOUR_DUMMY_P2;
        endcase
    end

    always_comb begin
        st_d = st_q;
        sck_prev_d = sck_s;
        cnt_d = cnt_q;
        sh_d = sh_q;
        op_d = op_q;
        cont_d = cont_q;
        cont_op_d = cont_op_q;
        wrap_d = wrap_q;
        addr_d = addr_q;
        dsh_d = dsh_q;
        rem_d = rem_q;
        lane_d = lane_q;
        oe_d = oe_q;
        byte_v = (rem_q == 4'd0) ? mem_data_i : dsh_q;
        if (cs_s) begin
            st_d = MFR_IDLE;
            oe_d = 4'h0;
            lane_d = 4'h0;
        end else begin
            case (st_q)
                MFR_IDLE: begin
                    wrap_d = 1'b0;
                    if (busy_i) begin
                        st_d = MFR_IGN;
                    end else if (cont_q) begin
                        st_d = MFR_ADDR;
                        op_d = cont_op_q;
                        wrap_d = wrap_en_i && !four_lane_command_mode_i
                                 && cont_op_q == `MFR_OP_QUAD_IO;
                        cnt_d = clocks(`MFR_ADDR_BITS, addr_w(cont_op_q,
                                       four_lane_command_mode_i));
                    end else begin
                        st_d = MFR_CMD;
                        cnt_d = clocks(`MFR_CMD_BITS, four_lane_command_mode_i ? 3'd4 : 3'd1);
                    end
                end
                MFR_CMD: if (rise) begin
                    sh_d = sh_in;
                    cnt_d = cnt_q - 5'd1;
                    if (cnt_q == 5'd1) begin
                        op_d = sh_in[7:0];
                        cnt_d = clocks(`MFR_ADDR_BITS, addr_w(sh_in[7:0],
                                       four_lane_command_mode_i));
                        st_d = MFR_ADDR;
                        case (sh_in[7:0])
                            `MFR_OP_DUAL_OUT, `MFR_OP_DUAL_IO: begin
                                if (four_lane_command_mode_i) st_d = MFR_IGN;
                            end
                            `MFR_OP_QUAD_OUT: begin
                                if (!quad_lane_enable_bit_i || four_lane_command_mode_i) begin
                                    st_d = MFR_IGN;
                                end
                            end
                            `MFR_OP_QUAD_IO: begin
                                if (!quad_lane_enable_bit_i) st_d = MFR_IGN;
                                // Wrap only outside four-lane mode
                                wrap_d = wrap_en_i && !four_lane_command_mode_i;
                            end
                            default: st_d = MFR_IGN;
                        endcase
                    end
                end
                MFR_ADDR: if (rise) begin
                    sh_d = sh_in;
                    cnt_d = cnt_q - 5'd1;
                    if (cnt_q == 5'd1) begin
                        addr_d = sh_in;
                        if (op_q == `MFR_OP_DUAL_IO || op_q == `MFR_OP_QUAD_IO) begin
                            st_d = MFR_MODE;
                            cnt_d = clocks(`MFR_MODE_BITS, addr_w(op_q,
                                           four_lane_command_mode_i));
                        end else begin
                            st_d = MFR_DUMMY;
                            cnt_d = `MFR_DUMMY_FIXED;
                        end
                    end
                end
                MFR_MODE: if (rise) begin
                    sh_d = sh_in;
                    cnt_d = cnt_q - 5'd1;
                    if (cnt_q == 5'd1) begin
                        // Lower nibble deliberately unused
                        cont_d = sh_in[7:4] == `MFR_CONT_KEY;
                        cont_op_d = op_q;
                        if (op_q == `MFR_OP_DUAL_IO) cnt_d = `MFR_DUMMY_DIO;
                        else if (four_lane_command_mode_i)
                            cnt_d = dum - `MFR_FOUR_MODE_CLKS;
                        else cnt_d = `MFR_DUMMY_SPI_QIO;
                        st_d = (cnt_d == 5'd0) ? MFR_DATA : MFR_DUMMY;
                        rem_d = 4'd0;
                    end
                end
                MFR_DUMMY: if (rise) begin
                    // Lane levels here are don't care
                    cnt_d = cnt_q - 5'd1;
                    if (cnt_q == 5'd1) begin
                        st_d = MFR_DATA;
                        rem_d = 4'd0;
                    end
                end
                MFR_DATA: if (fall) begin
                    if (data_w(op_q) == 3'd4) begin
                        lane_d = byte_v[7:4];
                        dsh_d = {byte_v[3:0], 4'h0};
                        oe_d = 4'hF;
                    end else begin
                        lane_d = {2'b00, byte_v[7:6]};
                        dsh_d = {byte_v[5:0], 2'b00};
                        oe_d = 4'h3;
                    end
                    if (rem_q == 4'd0) begin
                        rem_d = 4'(`MFR_BYTE_BITS / {1'b0, data_w(op_q)}) - 4'd1;
                        addr_d = next_addr(addr_q, wrap_q, wrap_len_i);
                    end else begin
                        rem_d = rem_q - 4'd1;
                    end
                end
                MFR_IGN: st_d = MFR_IGN;
                default: st_d = MFR_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_q <= MFR_IDLE;
            sck_prev_q <= 1'b1;
            cnt_q <= 5'd0;
            sh_q <= 24'h000000;
            op_q <= 8'h00;
            cont_q <= 1'b0;
            cont_op_q <= 8'h00;
            wrap_q <= 1'b0;
            addr_q <= 24'h000000;
            dsh_q <= 8'h00;
            rem_q <= 4'd0;
            lane_q <= 4'h0;
            oe_q <= 4'h0;
        end else begin
            st_q <= st_d;
            sck_prev_q <= sck_prev_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            op_q <= op_d;
            cont_q <= cont_d;
            cont_op_q <= cont_op_d;
            wrap_q <= wrap_d;
            addr_q <= addr_d;
            dsh_q <= dsh_d;
            rem_q <= rem_d;
            lane_q <= lane_d;
            oe_q <= oe_d;
        end
    end

    assign lane_o = lane_q;
    assign lane_oe_o = oe_q;
    assign mem_addr_o = addr_q;
    assign cont_mode_o = cont_q;

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);

    property p_quad_out_gate;
        st_q == MFR_CMD && rise && cnt_q == 5'd1 && !cs_s
            && sh_in[7:0] == `MFR_OP_QUAD_OUT && !quad_lane_enable_bit_i |=> st_q == MFR_IGN;
    endproperty
    a_quad_out_gate: assert property (p_quad_out_gate) else $error("quad out not refused");

    property p_quad_io_gate;
        st_q == MFR_CMD && rise && cnt_q == 5'd1 && !cs_s
            && sh_in[7:0] == `MFR_OP_QUAD_IO && !quad_lane_enable_bit_i |=> st_q == MFR_IGN;
    endproperty
    a_quad_io_gate: assert property (p_quad_io_gate) else $error("quad io not refused");

    property p_busy_ignore;
        st_q == MFR_IDLE && !cs_s && busy_i |=> st_q == MFR_IGN ##1 oe_q == 4'h0;
    endproperty
    a_busy_ignore: assert property (p_busy_ignore) else $error("read taken while busy");

    property p_fixed_dummy;
        st_q == MFR_ADDR ##1 (st_q == MFR_DUMMY
            && (op_q == `MFR_OP_DUAL_OUT || op_q == `MFR_OP_QUAD_OUT)) |-> cnt_q == 5'd8;
    endproperty
    a_fixed_dummy: assert property (p_fixed_dummy) else $error("dummy count not 8");

    property p_dual_lanes;
        st_q == MFR_DATA && (op_q == `MFR_OP_DUAL_OUT || op_q == `MFR_OP_DUAL_IO)
            |-> (oe_q == 4'h3 || oe_q == 4'h0) && lane_q[3:2] == 2'b00;
    endproperty
    a_dual_lanes: assert property (p_dual_lanes) else $error("dual data on wrong lanes");

    property p_quad_lanes;
        st_q == MFR_DATA && fall && !cs_s && op_q == `MFR_OP_QUAD_OUT |=> oe_q == 4'hF;
    endproperty
    a_quad_lanes: assert property (p_quad_lanes) else $error("quad data not on 4 lanes");

    property p_launch_fall;
        $changed(lane_q) && !$past(cs_s) |-> $past(fall);
    endproperty
    a_launch_fall: assert property (p_launch_fall) else $error("data not on falling edge");

    property p_cont_skip;
        st_q == MFR_IDLE && !cs_s && !busy_i && cont_q |=> st_q == MFR_ADDR;
    endproperty
    a_cont_skip: assert property (p_cont_skip) else $error("opcode not skipped");

    property p_cont_clear;
        st_q == MFR_MODE && rise && cnt_q == 5'd1 && !cs_s && sh_in[7:4] != `MFR_CONT_KEY
            |=> !cont_q;
    endproperty
    a_cont_clear: assert property (p_cont_clear) else $error("continuation kept");

    property p_four_dummy;
        st_q == MFR_MODE && rise && cnt_q == 5'd1 && !cs_s && four_lane_command_mode_i
            && op_q == `MFR_OP_QUAD_IO && read_param_i == 2'b00 |=> st_q == MFR_DUMMY
            && cnt_q == 5'd2;
    endproperty
    a_four_dummy: assert property (p_four_dummy) else $error("four-lane dummy count wrong");

    property p_addr_step;
        st_q == MFR_DATA && fall && !cs_s && rem_q == 4'd0 && !wrap_q
            |=> addr_q == $past(addr_q) + 24'h000001;
    endproperty
    a_addr_step: assert property (p_addr_step) else $error("address not advanced");

    // Bits inside the section forced high, so only bits above it are compared
    logic [7:0] sec_mask;
    assign sec_mask = (`MFR_WRAP_BASE << wrap_len_i) - 8'h01;

    property p_wrap_section;
        st_q == MFR_DATA && wrap_q && $changed(addr_q)
            |-> {addr_q[23:8], addr_q[7:0] | sec_mask}
                == {$past(addr_q[23:8]), $past(addr_q[7:0]) | sec_mask};
    endproperty
    a_wrap_section: assert property (p_wrap_section) else $error("wrap left section");

    property p_four_nowrap;
        st_q == MFR_DATA && four_lane_command_mode_i |-> !wrap_q;
    endproperty
    a_four_nowrap: assert property (p_four_nowrap) else $error("wrap in four-lane mode");

    c_dual_data: cover property (st_q == MFR_DATA && op_q == `MFR_OP_DUAL_OUT && fall);
    c_quad_io_cont: cover property (st_q == MFR_MODE ##1 cont_q);
    c_wrap_turn: cover property (wrap_q && st_q == MFR_DATA && $fell(addr_q[2]));
    c_ignored: cover property (st_q == MFR_IGN);
endmodule
`default_nettype wire

/* File: verif/mfr_host_model.sv */
// Host-side link model: drives chip select, serial clock and lanes of the read engine.
// Assumes the bench calls its tasks one at a time; the serial clock rests high between frames.
`timescale 1ns/100ps
`default_nettype none
module mfr_host_model (
    input wire logic sys_clk_i, // Bench clock, paces the float pattern
    input wire logic [3:0] dev_lane_i, // Device lane values
    input wire logic [3:0] dev_oe_i, // Device lane enables
    output var logic cs_n_o, // Chip select, active low
    output var logic sck_o, // Serial clock
    output logic [3:0] lane_o // Resolved lane levels
);
    localparam realtime HALF = 62.5;
    logic [3:0] h_val;
    logic [3:0] h_oe;
    logic [3:0] float_q = 4'h5;

    // Undriven lanes toggle, so a stale level never passes for data
    always @(posedge sys_clk_i) float_q <= ~float_q;
    assign lane_o = (dev_oe_i & dev_lane_i) | (~dev_oe_i & h_oe & h_val)
        | (~dev_oe_i & ~h_oe & float_q);

    initial begin
        cs_n_o = 1'b1;
        sck_o = 1'b1;
        h_val = 4'h0;
        h_oe = 4'h0;
    end

    function automatic logic [3:0] lmask(input int ln);
        return (ln == 1) ? 4'h1 : ((ln == 2) ? 4'h3 : 4'hF);
    endfunction

    task automatic begin_frame();
        cs_n_o = 1'b0;
        #(HALF);
    endtask

    task automatic end_frame();
        #(HALF);
        cs_n_o = 1'b1;
        #(4 * HALF);
    endtask

    task automatic shift(input logic [23:0] v, input int nb, input int ln);
        for (int c = 0; c < nb / ln; c++) begin
            sck_o = 1'b0;
            h_val = 4'(v >> (nb - ln * (c + 1))) & lmask(ln);
            h_oe = lmask(ln);
            #(HALF);
            sck_o = 1'b1;
            #(HALF / 2);
            if (c == nb / ln - 1) begin
                h_oe = 4'h0; // Freed before the next falling edge
            end
            #(HALF / 2);
        end
    endtask

    task automatic dummy(input int n);
        h_oe = 4'h0; // Dummy lanes left floating
        repeat (n) begin
            sck_o = 1'b0;
            #(HALF);
            sck_o = 1'b1;
            #(HALF);
        end
    endtask

    task automatic read(input int ln, output logic [7:0] by, output logic [3:0] oe);
        by = 8'h00;
        oe = 4'h0;
        for (int c = 0; c < 8 / ln; c++) begin
            sck_o = 1'b0;
            #(HALF - 2.0);
            by = (by << ln) | {4'h0, lane_o & lmask(ln)};
            oe = dev_oe_i;
            #(2.0);
            sck_o = 1'b1;
            #(HALF);
        end
    endtask
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
// Self-checking bench of the fast read engine, driven through the host link model.
// Assumes a combinational array model on mem_addr_o and static inputs set on falling edges.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import mfr_pkg::*;
    localparam int LIMIT = 80000;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic quad_en = 1'b0;
    logic four_mode = 1'b0;
    logic busy = 1'b0;
    logic wr_en = 1'b0;
    logic [1:0] wlen = 2'h0;
    logic [1:0] rpar = 2'h0;
    logic cs_n;
    logic sck;
    logic [3:0] lane;
    logic [3:0] d_lane;
    logic [3:0] d_oe;
    logic [23:0] maddr;
    logic [7:0] mdata;
    logic cont;
    int fails = 0;
    int num_checks = 0;
    int cyc = 0;
    logic [23:0] a;
    logic [7:0] r;
    int d;

    function automatic logic [7:0] mem_byte(input logic [23:0] x);
        return x[7:0] ^ x[15:8] ^ {x[19:16], x[23:20]} ^ 8'h3C;
    endfunction

    function automatic logic [23:0] nxt(input logic [23:0] x, input logic w, input logic [1:0] l);
        logic [23:0] m;
        m = (24'h8 << l) - 24'h1;
        return w ? ((x & ~m) | ((x + 24'h1) & m)) : x + 24'h1;
    endfunction

    assign mdata = mem_byte(maddr);

    mfr_engine u_dut (
        .sys_clk_i(clk),
        .resetn_i(rstn),
        .cs_n_i(cs_n),
        .sck_i(sck),
        .lane_i(lane),
        .lane_o(d_lane),
        .lane_oe_o(d_oe),
        .quad_lane_enable_bit_i(quad_en),
        .four_lane_command_mode_i(four_mode),
        .busy_i(busy),
        .wrap_en_i(wr_en),
        .wrap_len_i(wlen),
        .read_param_i(rpar),
        .mem_data_i(mdata),
        .mem_addr_o(maddr),
        .cont_mode_o(cont)
    );

    mfr_host_model u_host (
        .sys_clk_i(clk),
        .dev_lane_i(d_lane),
        .dev_oe_i(d_oe),
        .cs_n_o(cs_n),
        .sck_o(sck),
        .lane_o(lane)
    );

    initial begin
        forever #2 clk = ~clk;
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            fails++;
            final_report();
        end
    end

    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic cfg(input logic q, input logic p4, input logic b, input logic w,
                       input logic [1:0] l, input logic [1:0] p);
        @(negedge clk);
        quad_en = q;
        four_mode = p4;
        busy = b;
        wr_en = w;
        wlen = l;
        rpar = p;
    endtask

    // cl == 0 skips the opcode, ml == 0 skips the mode byte; ok == 0 expects a refusal
    task automatic rd(input logic [7:0] op, input int cl, input logic [23:0] ad, input int al,
                      input logic [7:0] md, input int ml, input int dm, input int dl,
                      input int n, input logic w, input logic [1:0] l, input logic ok);
        logic [7:0] by;
        logic [3:0] oe;
        logic [23:0] ea;
        ea = ad;
        u_host.begin_frame();
        if (cl != 0) begin
            u_host.shift({16'h0, op}, 8, cl);
        end
        u_host.shift(ad, 24, al);
        if (ml != 0) begin
            u_host.shift({16'h0, md}, 8, ml);
        end
        u_host.dummy(dm);
        for (int i = 0; i < n; i++) begin
            u_host.read(dl, by, oe);
            if (ok) begin
                check({16'h0, by}, {16'h0, mem_byte(ea)});
                check({20'h0, oe}, (dl == 2) ? 24'h3 : 24'hF);
                ea = nxt(ea, w, l);
            end else begin
                check({20'h0, oe}, 24'h0);
            end
        end
        u_host.end_frame();
    endtask

    initial begin
        void'($urandom(32'h0878074A));
        repeat (2) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        repeat (3) @(negedge clk);
        a = 24'($urandom());
        rd(8'h3B, 1, a, 1, 8'h00, 0, 8, 2, 5, 1'b0, 2'h0, 1'b1);
        rd(8'h6B, 1, a, 1, 8'h00, 0, 8, 4, 2, 1'b0, 2'h0, 1'b0);
        cfg(1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 2'h0);
        rd(8'h6B, 1, ~a, 1, 8'h00, 0, 8, 4, 4, 1'b0, 2'h0, 1'b1);
        cfg(1'b1, 1'b0, 1'b1, 1'b0, 2'h0, 2'h0);
        rd(8'h3B, 1, a, 1, 8'h00, 0, 8, 2, 2, 1'b0, 2'h0, 1'b0);
        cfg(1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 2'h0);
        r = 8'($urandom());
        a = 24'($urandom());
        rd(8'hBB, 1, a, 2, {4'hA, r[3:0]}, 2, 0, 2, 4, 1'b0, 2'h0, 1'b1);
        check({23'h0, cont}, 24'h1);
        rd(8'h00, 0, ~a, 2, {4'h5, r[7:4]}, 2, 0, 2, 3, 1'b0, 2'h0, 1'b1);
        check({23'h0, cont}, 24'h0);
        rd(8'hBB, 1, a + 24'h10, 2, 8'h00, 2, 0, 2, 2, 1'b0, 2'h0, 1'b1);
        cfg(1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 2'h0);
        rd(8'hEB, 1, a, 4, 8'h00, 4, 4, 4, 2, 1'b0, 2'h0, 1'b0);
        for (int l = 0; l < 4; l++) begin
            cfg(1'b1, 1'b0, 1'b0, 1'b1, 2'(l), 2'h0);
            a = 24'($urandom());
            r = 8'($urandom());
            rd(8'hEB, 1, a, 4, {4'h3, r[3:0]}, 4, 4, 4, (8 << l) + 3, 1'b1, 2'(l), 1'b1);
        end
        // Wrap off: a read started near a section end must run straight on
        cfg(1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 2'h0);
        a = {a[23:3], 3'h6};
        rd(8'hEB, 1, a, 4, 8'h00, 4, 4, 4, 4, 1'b0, 2'h0, 1'b1);
        rd(8'h0B, 1, a, 1, 8'h00, 0, 8, 2, 1, 1'b0, 2'h0, 1'b0);
        for (int p = 0; p < 4; p++) begin
            cfg(1'b1, 1'b1, 1'b0, 1'b1, 2'h0, 2'(p));
            d = (p == 0) ? 2 : ((p == 1) ? 4 : 6);
            a = 24'($urandom());
            rd(8'hEB, 4, a, 4, 8'hA7, 4, d, 4, 10, 1'b0, 2'h0, 1'b1);
            check({23'h0, cont}, 24'h1);
            rd(8'h00, 0, ~a, 4, 8'h00, 4, d, 4, 3, 1'b0, 2'h0, 1'b1);
            check({23'h0, cont}, 24'h0);
        end
        rd(8'hBB, 4, a, 2, 8'h00, 2, 0, 2, 2, 1'b0, 2'h0, 1'b0);
        final_report();
    end
endmodule
`default_nettype wire
